// [dsi_pkg.sv]
// Shared constants and state types for the dual-section two-wire target and its bus master.
// Assumes a 200 MHz system clock on both ends.
package dsi_pkg;

  localparam int CLK_PERIOD_NS = 5;
  // Quarter of the master's serial clock period
  localparam int HOST_QUARTER_NS = 50;
  localparam int HOST_QUARTER_CYCLES = (HOST_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Address byte layout
  localparam logic [4:0] ADDR_PREFIX = 5'h02;
  localparam int ADDR_PREFIX_LSB = 3;
  localparam int ADDR_SECTION_BIT = 2;
  localparam int ADDR_PIN_BIT = 1;
  localparam int ADDR_RW_BIT = 0;

  // System register, control view
  localparam int CTRL_CURRENT_LIMIT_MODE = 7;
  localparam int CTRL_TONE_TRANSMIT_ENABLE = 6;
  localparam int CTRL_TONE_ALWAYS_ON = 5;
  localparam int CTRL_LINE_LOSS_BOOST = 4;
  localparam int CTRL_VOLTAGE_LEVEL_SELECT = 3;
  localparam int CTRL_POWER_BLOCK_ENABLE = 2;
  localparam int CTRL_MIN_CURRENT_THRESHOLD_SELECT = 1;
  localparam int CTRL_AUX_HIGH_VOLTAGE = 0;

  // System register, diagnostic view
  localparam int DIAG_MIN_CURRENT_FAULT = 7;
  localparam int DIAG_VOLTAGE_FAULT = 6;
  localparam int DIAG_TONE_FAULT = 5;
  localparam int DIAG_LINE_LOSS_BOOST = 4;
  localparam int DIAG_VOLTAGE_LEVEL_SELECT = 3;
  localparam int DIAG_POWER_BLOCK_ENABLE = 2;
  localparam int DIAG_THERMAL_FAULT = 1;
  localparam int DIAG_OVERLOAD_FAULT = 0;

  // Fault input vector positions
  localparam int FLT_MIN_CURRENT = 4;
  localparam int FLT_VOLTAGE = 3;
  localparam int FLT_TONE = 2;
  localparam int FLT_THERMAL = 1;
  localparam int FLT_OVERLOAD = 0;

  localparam logic [7:0] SYSTEM_REGISTER_RESET = 8'h00;

  // Master command registers
  localparam logic [2:0] HOST_REG_ADDR = 3'h0;
  localparam logic [2:0] HOST_REG_WDATA = 3'h1;
  localparam logic [2:0] HOST_REG_CTRL = 3'h2;
  localparam logic [2:0] HOST_REG_STATUS = 3'h3;
  localparam logic [2:0] HOST_REG_RDATA = 3'h4;
  localparam int HOST_CTRL_GO_BIT = 0;
  localparam int HOST_CTRL_SKIP_ACK_BIT = 1;
  localparam int HOST_CTRL_EXTRA_LSB = 4;
  localparam int HOST_STAT_BUSY_BIT = 0;
  localparam int HOST_STAT_DONE_BIT = 1;
  localparam int HOST_STAT_ADDR_NACK_BIT = 2;
  localparam int HOST_STAT_DATA_NACK_BIT = 3;
  localparam logic [7:0] HOST_REG_RESET = 8'h00;

  typedef enum logic [2:0]
  {
    DEV_IDLE = 3'h0,
    DEV_ADDR = 3'h1,
    DEV_ADDR_ACK = 3'h3,
    DEV_WDATA = 3'h2,
    DEV_WACK = 3'h6,
    DEV_RDATA = 3'h7,
    DEV_RACK = 3'h5,
    DEV_IGNORE = 3'h4
  } dsi_dev_state_e;

  typedef enum logic [1:0]
  {
    HST_IDLE = 2'h0,
    HST_START = 2'h1,
    HST_XFER = 2'h3,
    HST_STOP = 2'h2
  } dsi_host_state_e;

endpackage

// [dsi_i2c_if.sv]
// Two-wire bus between master and target, open-drain with pull-up.
// Assumes each party pulls a line low only while its enable is high and its output is 0.
`timescale 1ns/1ps
interface dsi_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o,
                output host_sda_oe);
endinterface

// [dsi_device.sv]
// Dual-section two-wire target: one control byte and one diagnostic byte per section.
// Assumes the master makes the serial clock; all pins are oversampled by clk_i.
`timescale 1ns/1ps
module dsi_device
  import dsi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  dsi_i2c_if.device bus,
  input wire logic addr_sel_a_i,
  input wire logic addr_sel_b_i,
  input wire logic uvlo_i,
  input wire logic [4:0] fault_a_i,
  input wire logic [4:0] fault_b_i,
  output logic [7:0] ctrl_a_o,
  output logic [7:0] ctrl_b_o
);

  localparam int SYNC_W = 15;
  // Clock and data lines sit in the two low bits and idle high
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 15'h0003;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic scl_q_r, sda_q_r;
  logic scl_s, sda_s, uvlo_s, sel_a_s, sel_b_s;
  logic [4:0] flt_a_s, flt_b_s;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic addr_hit, byte_end;
  logic [7:0] diag_sel;
  dsi_dev_state_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic sect_r, rw_r, mack_r, sda_oe_r, sda_o_r;
  logic [7:0] ctrl_a_r, ctrl_b_r;

  // Diagnostic view: faults around echoed control bits
  function automatic logic [7:0] diag_byte(input logic [7:0] ctrl, input logic [4:0] flt);
    logic [7:0] d;
    d = 8'h00;
    d[DIAG_MIN_CURRENT_FAULT] = flt[FLT_MIN_CURRENT];
    d[DIAG_VOLTAGE_FAULT] = flt[FLT_VOLTAGE];
    d[DIAG_TONE_FAULT] = flt[FLT_TONE];
    d[DIAG_LINE_LOSS_BOOST] = ctrl[CTRL_LINE_LOSS_BOOST];
    d[DIAG_VOLTAGE_LEVEL_SELECT] = ctrl[CTRL_VOLTAGE_LEVEL_SELECT];
    d[DIAG_POWER_BLOCK_ENABLE] = ctrl[CTRL_POWER_BLOCK_ENABLE];
    d[DIAG_THERMAL_FAULT] = flt[FLT_THERMAL];
    d[DIAG_OVERLOAD_FAULT] = flt[FLT_OVERLOAD];
    return d;
  endfunction

  // Two-stage synchroniser for every pin, then line history for edges
  // Reset to the idle bus level so no false edge follows reset
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      meta_r <= {fault_b_i, fault_a_i, addr_sel_b_i, addr_sel_a_i, uvlo_i, bus.sda, bus.scl};
      sync_r <= meta_r;
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign {flt_b_s, flt_a_s, sel_b_s, sel_a_s, uvlo_s, sda_s, scl_s} = sync_r;

  assign scl_rise = scl_s && !scl_q_r;
  assign scl_fall = !scl_s && scl_q_r;
  assign start_det = scl_s && scl_q_r && sda_q_r && !sda_s;
  assign stop_det = scl_s && scl_q_r && !sda_q_r && sda_s;

  // Prefix match, section bit picks which pin the next bit must equal
  assign addr_hit = (shift_r[7:ADDR_PREFIX_LSB] == ADDR_PREFIX) &&
                    (shift_r[ADDR_PIN_BIT] == (shift_r[ADDR_SECTION_BIT] ? sel_b_s : sel_a_s));
  assign byte_end = scl_fall && (bit_cnt_r == BITS_PER_BYTE);
  assign diag_sel = sect_r ? diag_byte(ctrl_b_r, flt_b_s) : diag_byte(ctrl_a_r, flt_a_s);

  // Protocol engine; data line only moves on a detected clock fall
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= DEV_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sect_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_o_r <= 1'b0; // Open drain: only ever pulls low
    end
    else if (start_det)
    begin
      state_r <= DEV_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= DEV_IDLE;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        DEV_IDLE, DEV_IGNORE:
        begin
        end
        DEV_ADDR:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_end)
          begin
            bit_cnt_r <= 4'h0;
            if (addr_hit && !uvlo_s)
            begin
              state_r <= DEV_ADDR_ACK;
              sda_oe_r <= 1'b1;
              sect_r <= shift_r[ADDR_SECTION_BIT];
              rw_r <= shift_r[ADDR_RW_BIT];
            end
            else
            begin
              state_r <= DEV_IGNORE;
            end
          end
        end
        DEV_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            if (rw_r)
            begin
              state_r <= DEV_RDATA;
              shift_r <= diag_sel;
              sda_oe_r <= !diag_sel[7];
            end
            else
            begin
              state_r <= DEV_WDATA;
              sda_oe_r <= 1'b0;
            end
          end
        end
        DEV_WDATA:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_end)
          begin
            bit_cnt_r <= 4'h0;
            state_r <= uvlo_s ? DEV_IGNORE : DEV_WACK;
            sda_oe_r <= !uvlo_s;
          end
        end
        DEV_WACK:
        begin
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            state_r <= DEV_IGNORE;
          end
        end
        DEV_RDATA:
        begin
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (byte_end)
          begin
            bit_cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
            state_r <= DEV_RACK;
          end
          else if (scl_fall)
          begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_r <= !shift_r[6];
          end
        end
        DEV_RACK:
        begin
          if (scl_rise)
          begin
            mack_r <= !sda_s;
          end
          else if (scl_fall)
          begin
            if (mack_r)
            begin
              state_r <= DEV_RDATA;
              shift_r <= diag_sel;
              sda_oe_r <= !diag_sel[7];
            end
            else
            begin
              state_r <= DEV_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // Section control bytes, held clear while the supply is locked out
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      ctrl_a_r <= SYSTEM_REGISTER_RESET;
      ctrl_b_r <= SYSTEM_REGISTER_RESET;
    end
    else if (uvlo_s)
    begin
      ctrl_a_r <= SYSTEM_REGISTER_RESET;
      ctrl_b_r <= SYSTEM_REGISTER_RESET;
    end
    else if (state_r == DEV_WDATA && byte_end && !start_det && !stop_det)
    begin
      if (sect_r)
        ctrl_b_r <= shift_r;
      else
        ctrl_a_r <= shift_r;
    end
  end

  assign bus.dev_sda_oe = sda_oe_r;
  assign bus.dev_sda_o = sda_o_r;
  assign ctrl_a_o = ctrl_a_r;
  assign ctrl_b_o = ctrl_b_r;

endmodule

// [dsi_host.sv]
// Two-wire bus master that issues one transfer per software order.
// Assumes a plain register port with read data one cycle after the read strobe.
`timescale 1ns/1ps
module dsi_host
  import dsi_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  dsi_i2c_if.host bus,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  logic sda_meta_r;
  logic sda_s_r;
  logic [7:0] qcnt_r;
  logic tick;
  logic [7:0] addr_byte_r;
  logic [7:0] wdata_r;
  logic skip_ack_r;
  logic [3:0] extra_r;
  logic go_pend_r;
  dsi_host_state_e state_r;
  logic [1:0] ph_r;
  logic [3:0] bit_idx_r;
  logic byte_idx_r;
  logic [3:0] rd_left_r;
  logic [7:0] rx_r;
  logic nack_now_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic line_o_r;
  logic done_r;
  logic anack_r;
  logic dnack_r;
  logic [7:0] rbyte_r;
  logic [7:0] rdata_r;
  logic busy;
  logic sending;
  logic bit_last;
  logic [7:0] tx_byte;
  logic go_wr;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sda_meta_r <= 1'b1;
      sda_s_r <= 1'b1;
    end
    else
    begin
      sda_meta_r <= bus.sda;
      sda_s_r <= sda_meta_r;
    end
  end

  // Quarter-period tick of the serial clock
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      qcnt_r <= 8'h00;
    else if (tick)
      qcnt_r <= 8'h00;
    else
      qcnt_r <= qcnt_r + 8'h01;
  end
  assign tick = qcnt_r == 8'(HOST_QUARTER_CYCLES - 1);

  assign busy = go_pend_r || (state_r != HST_IDLE);
  assign go_wr = reg_wr_i && reg_addr_i == HOST_REG_CTRL && reg_wdata_i[HOST_CTRL_GO_BIT] && !busy;

  // Order registers, frozen while a transfer runs
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      addr_byte_r <= HOST_REG_RESET;
      wdata_r <= HOST_REG_RESET;
      skip_ack_r <= 1'b0;
      extra_r <= 4'h0;
    end
    else if (reg_wr_i && !busy)
    begin
      if (reg_addr_i == HOST_REG_ADDR)
        addr_byte_r <= reg_wdata_i;
      if (reg_addr_i == HOST_REG_WDATA)
        wdata_r <= reg_wdata_i;
      if (reg_addr_i == HOST_REG_CTRL)
      begin
        skip_ack_r <= reg_wdata_i[HOST_CTRL_SKIP_ACK_BIT];
        extra_r <= reg_wdata_i[HOST_CTRL_EXTRA_LSB +: 4];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      go_pend_r <= 1'b0;
    else if (go_wr)
      go_pend_r <= 1'b1;
    else if (tick && state_r == HST_IDLE)
      go_pend_r <= 1'b0;
  end

  assign sending = !byte_idx_r || !addr_byte_r[ADDR_RW_BIT];
  assign tx_byte = byte_idx_r ? wdata_r : addr_byte_r;
  assign bit_last = bit_idx_r == BITS_PER_BYTE;

  // Bus sequencer: four quarters per bit, bit data moves only in quarter 0 with clock low; start and stop move it with clock high
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= HST_IDLE;
      ph_r <= 2'h0;
      bit_idx_r <= 4'h0;
      byte_idx_r <= 1'b0;
      rd_left_r <= 4'h0;
      rx_r <= 8'h00;
      nack_now_r <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      done_r <= 1'b0;
      anack_r <= 1'b0;
      dnack_r <= 1'b0;
      rbyte_r <= 8'h00;
    end
    else if (tick)
    begin
      ph_r <= (state_r == HST_IDLE) ? 2'h0 : ph_r + 2'h1;
      unique case (state_r)
        HST_IDLE:
        begin
          // Bus is always left stopped, so a new start follows a stop
          if (go_pend_r)
          begin
            state_r <= HST_START;
            done_r <= 1'b0;
            anack_r <= 1'b0;
            dnack_r <= 1'b0;
            bit_idx_r <= 4'h0;
            byte_idx_r <= 1'b0;
            rd_left_r <= extra_r;
          end
        end
        HST_START:
        begin
          if (ph_r == 2'h1)
            sda_oe_r <= 1'b1;
          if (ph_r == 2'h2)
            scl_oe_r <= 1'b1;
          if (ph_r == 2'h3)
            state_r <= HST_XFER;
        end
        HST_XFER:
        begin
          if (ph_r == 2'h0)
          begin
            if (bit_last)
              sda_oe_r <= sending ? 1'b0 : (rd_left_r != 4'h0);
            else
              sda_oe_r <= sending ? !tx_byte[3'h7 - bit_idx_r[2:0]] : 1'b0;
          end
          if (ph_r == 2'h1)
            scl_oe_r <= 1'b0;
          if (ph_r == 2'h2)
          begin
            nack_now_r <= sda_s_r;
            if (!bit_last && !sending)
              rx_r <= {rx_r[6:0], sda_s_r};
            if (bit_last && sending && sda_s_r)
            begin
              if (byte_idx_r)
                dnack_r <= 1'b1;
              else
                anack_r <= 1'b1;
            end
          end
          if (ph_r == 2'h3)
          begin
            scl_oe_r <= 1'b1;
            if (!bit_last)
              bit_idx_r <= bit_idx_r + 4'h1;
            else
            begin
              bit_idx_r <= 4'h0;
              if (sending)
              begin
                if (nack_now_r && !skip_ack_r)
                  state_r <= HST_STOP;
                else if (!byte_idx_r)
                  byte_idx_r <= 1'b1;
                else
                  state_r <= HST_STOP;
              end
              else
              begin
                rbyte_r <= rx_r;
                if (rd_left_r != 4'h0)
                  rd_left_r <= rd_left_r - 4'h1;
                else
                  state_r <= HST_STOP;
              end
            end
          end
        end
        HST_STOP:
        begin
          if (ph_r == 2'h0)
            sda_oe_r <= 1'b1;
          if (ph_r == 2'h1)
            scl_oe_r <= 1'b0;
          if (ph_r == 2'h2)
            sda_oe_r <= 1'b0;
          if (ph_r == 2'h3)
          begin
            state_r <= HST_IDLE;
            done_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_r <= 8'h00;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        HOST_REG_ADDR: rdata_r <= addr_byte_r;
        HOST_REG_WDATA: rdata_r <= wdata_r;
        HOST_REG_CTRL: rdata_r <= {extra_r, 2'h0, skip_ack_r, 1'b0};
        HOST_REG_STATUS: rdata_r <= {4'h0, dnack_r, anack_r, done_r, busy};
        HOST_REG_RDATA: rdata_r <= rbyte_r;
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      line_o_r <= 1'b0;
    else
      line_o_r <= 1'b0;
  end

  assign bus.host_scl_o = line_o_r;
  assign bus.host_sda_o = line_o_r;
  assign bus.host_scl_oe = scl_oe_r;
  assign bus.host_sda_oe = sda_oe_r;
  assign reg_rdata_o = rdata_r;

endmodule

// [dsi_bus_monitor.sv]
// Checker on the shared two-wire bus: resolved lines and each party's enables.
// Assumes one clock domain with async active-high reset; instantiated beside the interface.
`timescale 1ns/1ps
module dsi_bus_monitor
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] bits_r;
  logic start_w;
  logic stop_w;

  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  assign start_w = scl && scl_q_r && sda_q_r && !sda;
  assign stop_w = scl && scl_q_r && !sda_q_r && sda;

  // Clock rises since the last start
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      bits_r <= 8'h00;
    end
    else
    begin
      scl_q_r <= scl;
      sda_q_r <= sda;
      if (start_w)
        bits_r <= 8'h00;
      else if (scl && !scl_q_r)
        bits_r <= bits_r + 8'h01;
    end
  end

  sequence ack_hold_s;
    (dev_sda_oe && !sda)[*8];
  endsequence

  sequence bus_idle_s;
    scl[*8];
  endsequence

  data_stable_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while clock high");
  start_cause_a: assert property (scl && $fell(sda) |-> $rose(host_sda_oe))
    else $error("data fell with clock high without host start");
  stop_cause_a: assert property (scl && $rose(sda) |-> $fell(host_sda_oe))
    else $error("data rose with clock high without host stop");
  idle_after_a: assert property (scl && $rose(sda) |=> bus_idle_s)
    else $error("clock moved right after stop");
  clock_low_a: assert property ($rose(host_scl_oe) |-> ##[15:35] $fell(host_scl_oe))
    else $error("serial clock low phase out of range");
  host_release_a: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("host drives data during device slot");
  ack_hold_a: assert property ($rose(scl) && dev_sda_oe |-> ack_hold_s)
    else $error("device low level not held through clock high");
  frame_bits_a: assert property (stop_w |-> bits_r > 8'h01 && bits_r % 9 == 1)
    else $error("stop not on a nine-bit boundary");
endmodule

// [tb_top.sv]
// Self-checking bench: host and device joined on one bus, driven through host registers.
// Assumes 200 MHz clock, async high reset, register read data one cycle after strobe.
`timescale 1ns/1ps
module tb_top;
  import dsi_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [1:0] sel_r = 2'h0;
  logic uvlo_i = 1'b0;
  logic [4:0] flt_a = 5'h00;
  logic [4:0] flt_b = 5'h00;
  logic [7:0] ctrl_a_o;
  logic [7:0] ctrl_b_o;
  logic [7:0] exp_c [2] = '{8'h00, 8'h00};
  logic [31:0] seed = 32'h1f;
  int err_count = 0;
  int num_checks = 0;

  dsi_i2c_if bus_if ();
  dsi_host u_dsi_host (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
  dsi_device u_dsi_device (.clk_i(clk_i), .reset_i(reset_i), .bus(bus_if), .addr_sel_a_i(sel_r[0]),
    .addr_sel_b_i(sel_r[1]), .uvlo_i(uvlo_i), .fault_a_i(flt_a), .fault_b_i(flt_b),
    .ctrl_a_o(ctrl_a_o), .ctrl_b_o(ctrl_b_o));
  dsi_bus_monitor u_dsi_bus_monitor (.clk_i(clk_i), .reset_i(reset_i), .host_scl_oe(bus_if.host_scl_oe),
    .host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [7:0] adr(input logic s, input logic p, input logic rw);
    return {ADDR_PREFIX, s, p, rw};
  endfunction

  function automatic logic [7:0] diag(input logic [4:0] f, input logic [7:0] c);
    return {f[4], f[3], f[2], c[4:2], f[1], f[0]};
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkc();
    chk("ctrl_a", exp_c[0], ctrl_a_o);
    chk("ctrl_b", exp_c[1], ctrl_b_o);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  // One bus transfer, then its final status
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic [7:0] c, input logic [7:0] st);
    logic [7:0] s;
    int n;
    n = 0;
    s = 8'h01;
    wr(HOST_REG_ADDR, a);
    wr(HOST_REG_WDATA, d);
    wr(HOST_REG_CTRL, c | 8'h01);
    while (s[HOST_STAT_BUSY_BIT] !== 1'b0 && n < 2000)
    begin
      rd(HOST_REG_STATUS, s);
      n++;
    end
    chk("status", st, s);
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
    forever #2.5 clk_i = ~clk_i;

  initial
  begin
    // About three and a half times the expected length of all scenarios
    repeat (60000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end

  initial
  begin
    logic [7:0] v;
    logic [7:0] d;
    logic [4:0] fa;
    logic [4:0] fb;
    logic [1:0] sp;
    logic s;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    chkc();
    rd(HOST_REG_STATUS, v);
    chk("status", 8'h00, v);
    rd(3'h7, v);
    chk("unmapped", 8'h00, v);
    for (int i = 0; i < 8; i++)
    begin
      v = rnd();
      fa = v[4:0];
      v = rnd();
      fb = v[4:0];
      v = rnd();
      sp = v[1:0];
      s = v[2];
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : rnd();
      @(posedge clk_i);
      sel_r <= sp;
      flt_a <= fa;
      flt_b <= fb;
      xfer(adr(s, sp[s], 1'b0), d, (i == 2) ? 8'h02 : 8'h00, 8'h02);
      exp_c[s] = d;
      chkc();
      xfer(adr(s, sp[s], 1'b1), 8'h00, (i == 3) ? 8'h10 : 8'h00, 8'h02);
      rd(HOST_REG_RDATA, v);
      chk("diag", diag(s ? fb : fa, exp_c[s]), v);
    end
    for (int j = 0; j < 3; j++)
    begin
      v = (j == 0) ? adr(1'b0, !sp[0], 1'b0) : (j == 1) ? adr(1'b1, !sp[1], 1'b0) : 8'h30;
      xfer(v, rnd(), 8'h00, 8'h06);
      chkc();
    end
    @(posedge clk_i);
    uvlo_i <= 1'b1;
    xfer(adr(1'b0, sp[0], 1'b0), 8'h5a, 8'h00, 8'h06);
    exp_c[0] = 8'h00;
    exp_c[1] = 8'h00;
    chkc();
    @(posedge clk_i);
    uvlo_i <= 1'b0;
    xfer(adr(1'b1, sp[1], 1'b0), 8'ha5, 8'h00, 8'h02);
    exp_c[1] = 8'ha5;
    chkc();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    exp_c[1] = 8'h00;
    chkc();
    xfer(adr(1'b0, sp[0], 1'b0), 8'h3c, 8'h00, 8'h02);
    exp_c[0] = 8'h3c;
    chkc();
    end_of_test();
  end
endmodule
